// ### logic/fpc_map.vh
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// Commands on the user port
`define FPC_CMD_READ      3'h0
`define FPC_CMD_WRITE     3'h1
`define FPC_CMD_ERASE     3'h2
`define FPC_CMD_SIG_MAKER 3'h3
`define FPC_CMD_SIG_PROD  3'h4

// Timing in ns, and in cycles of the 20 MHz reference clock
`define FPC_CLK_NS        50
`define FPC_WC_MIN_NS     75000
`define FPC_WC_CYC        ((`FPC_WC_MIN_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_TMR_NS        150000
`define FPC_TMR_CYC       (`FPC_TMR_NS / `FPC_CLK_NS)
`define FPC_RD_NS         300
`define FPC_RD_CYC        ((`FPC_RD_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_SU_NS         100
`define FPC_SU_CYC        ((`FPC_SU_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

// Loop counts, data values, signature pin bit and address width
`define FPC_WRITE_LOOPS   3
`define FPC_ERASE_LOOPS   20
`define FPC_BLANK         8'hff
`define FPC_SIG_PIN_BIT   9
`define FPC_ADDR_BITS     16

`endif

// ### logic/fpc_cycle.v
`timescale 1ns/1ps
`default_nettype none
`include "fpc_map.vh"
// Single strobe cycle on the device pins: hold low, release, then setup count before done
module fpc_cycle #(
    parameter CW = 13
) (
    // Clock and reset
    input  wire          i_ref_clk,
    input  wire          i_rst,
    // Control
    input  wire          i_start,
    input  wire [CW-1:0] i_low_cyc,
    // Status
    output reg           o_strobe,
    output reg           o_done
);
    localparam integer SU_I = `FPC_SU_CYC;
    localparam [31:0]  SU_W = SU_I;

    reg [CW-1:0] cnt_q;
    reg [1:0]    ph_q;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q    <= {CW{1'b0}};
            ph_q     <= 2'h0;
            o_strobe <= 1'b0;
            o_done   <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (ph_q)
                2'h0: begin
                    if (i_start) begin
                        ph_q     <= 2'h1;
                        o_strobe <= 1'b1;
                        cnt_q    <= i_low_cyc;
                    end
                end
                2'h1: begin
                    if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
                        o_strobe <= 1'b0;
                        ph_q     <= 2'h2;
                        cnt_q    <= SU_W[CW-1:0];
                    end else begin
                        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                2'h2: begin
                    if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
                        ph_q   <= 2'h0;
                        o_done <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                default: ph_q <= 2'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### logic/fpc_host.v
// Summary of operation
// R1 - Array is 65536 bytes, 16-bit address, 8-bit two-way data bus.
// R2 - Read: chip select and output gate low, write strobe high, address valid.
// R3 - Device writes and erases only with program supply at program level.
// R4 - Device latches address on later falling edge of strobe or select.
// R5 - Device latches data on earlier rising edge of strobe or select.
// R6 - Device ignores write strobe pulses shorter than 20 ns.
// R7 - Write or erase begins only with select low, gate high, strobe low.
// R8 - Select-controlled writes behave like strobe-controlled writes.
// R9 - Writes only clear bits; ones need chip erase then rewrite.
// R10 - Host skips write cycles for bytes whose value is FF.
// R11 - Host holds each byte write cycle active at least 75 us.
// R12 - Device times writes; its timer ends a cycle after 150 us.
// R13 - Host runs three write loops, verifies, then fill-in loop for failures.
// R14 - Completed chip erase sets every array bit to one.
// R15 - Host does an erase select before every erase cycle.
// R16 - Write cycle with supply at logic level acts as erase select.
// R17 - Erase starts after select only with data FF and program level.
// R18 - Host repeats select-then-erase 20 times, then verifies all FF.
// R19 - Device blocks writes and erases while supply below 3.5 V.
// R20 - Identification: trigger pin at 12 V, other address low, select, gate low.
// R21 - Low address bit picks maker code or product code.
// R22 - Select high: device floats data and ignores all inputs.
// R23 - Gate high without read: device leaves data bus for host to drive.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_map.vh"
module fpc_host #(
    parameter AW     = `FPC_ADDR_BITS,
    parameter WC_CYC = `FPC_WC_CYC,
    parameter RD_CYC = `FPC_RD_CYC
) (
    // Clock and reset
    input  wire          i_ref_clk,
    input  wire          i_rst,
    // User command port
    input  wire          i_cmd_valid,
    input  wire [2:0]    i_cmd,
    input  wire [AW-1:0] i_addr,
    input  wire [7:0]    i_wdata,
    output reg           o_busy,
    output reg           o_done,
    output reg           o_ok,
    output reg  [7:0]    o_rdata,
    // Device pins
    output reg  [AW-1:0] o_addr,
    input  wire [7:0]    i_dq,
    output reg  [7:0]    o_dq,
    output reg           o_dq_oe,
    output reg           o_chip_select_n,
    output reg           o_output_gate_n,
    output reg           o_write_strobe_n,
    output reg           o_prog_level_en,
    output reg           o_sig_high_volt
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_READ  = 3'h1;
    localparam ST_SEL   = 3'h2;
    localparam ST_WR    = 3'h3;
    localparam ST_VFY   = 3'h4;
    localparam ST_FINAL = 3'h5;
    localparam CW       = 13;

    reg [2:0]    st_q;
    reg [2:0]    cmd_q;
    reg [4:0]    loop_q;
    reg [AW-1:0] vaddr_q;
    reg [CW-1:0] rcnt_q;
    reg          erase_q;
    reg          cyc_start_q;
    reg [CW-1:0] cyc_len_q;
    wire         cyc_strobe;
    wire         cyc_done;

    function [CW-1:0] fit;
        input integer v;
        begin
            fit = v[CW-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Strobe timing
    fpc_cycle #(
        .CW (CW)
    ) u_cycle (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_start   (cyc_start_q),
        .i_low_cyc (cyc_len_q),
        .o_strobe  (cyc_strobe),
        .o_done    (cyc_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q             <= ST_IDLE;
            cmd_q            <= 3'h0;
            loop_q           <= 5'h00;
            vaddr_q          <= {AW{1'b0}};
            rcnt_q           <= {CW{1'b0}};
            erase_q          <= 1'b0;
            cyc_start_q      <= 1'b0;
            cyc_len_q        <= {CW{1'b0}};
            o_busy           <= 1'b0;
            o_done           <= 1'b0;
            o_ok             <= 1'b0;
            o_rdata          <= 8'h00;
            o_addr           <= {AW{1'b0}};
            o_dq             <= 8'h00;
            o_dq_oe          <= 1'b0;
            o_chip_select_n  <= 1'b1;
            o_output_gate_n  <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_prog_level_en  <= 1'b0;
            o_sig_high_volt  <= 1'b0;
        end else begin
            o_done      <= 1'b0;
            cyc_start_q <= 1'b0;
            o_write_strobe_n <= ~cyc_strobe;                      // [R7] [R6]
            case (st_q)
                ST_IDLE: begin
                    o_chip_select_n <= 1'b1;                      // [R22]
                    o_output_gate_n <= 1'b1;
                    o_dq_oe         <= 1'b0;
                    o_sig_high_volt <= 1'b0;
                    o_prog_level_en <= 1'b0;
                    if (i_cmd_valid) begin
                        o_busy <= 1'b1;
                        cmd_q  <= i_cmd;
                        loop_q <= 5'h00;
                        o_addr <= i_addr;                         // [R1]
                        o_dq   <= i_wdata;
                        case (i_cmd)
                            `FPC_CMD_WRITE: begin
                                if (i_wdata == `FPC_BLANK) begin  // [R10]
                                    o_ok   <= 1'b1;
                                    o_done <= 1'b1;
                                    o_busy <= 1'b0;
                                end else begin
                                    o_prog_level_en <= 1'b1;      // [R3]
                                    st_q <= ST_WR;
                                    rcnt_q <= fit(RD_CYC);
                                end
                            end
                            `FPC_CMD_ERASE: begin
                                st_q   <= ST_SEL;
                                rcnt_q <= fit(RD_CYC);
                            end
                            `FPC_CMD_SIG_MAKER, `FPC_CMD_SIG_PROD: begin
                                o_addr <= {AW{1'b0}};             // [R20]
                                o_addr[0] <= (i_cmd == `FPC_CMD_SIG_PROD); // [R21]
                                o_sig_high_volt <= 1'b1;
                                o_chip_select_n <= 1'b0;
                                o_output_gate_n <= 1'b0;
                                rcnt_q <= fit(RD_CYC);
                                st_q   <= ST_READ;
                            end
                            default: begin
                                o_chip_select_n <= 1'b0;          // [R2]
                                o_output_gate_n <= 1'b0;
                                rcnt_q <= fit(RD_CYC);
                                st_q   <= ST_READ;
                            end
                        endcase
                    end
                end
                ST_READ: begin
                    if (rcnt_q <= fit(1)) begin
                        o_rdata <= i_dq;
                        o_ok    <= 1'b1;
                        o_done  <= 1'b1;
                        o_busy  <= 1'b0;
                        st_q    <= ST_IDLE;
                    end else begin
                        rcnt_q <= rcnt_q - fit(1);
                    end
                end
                ST_SEL: begin
                    // Select cycle with supply at logic level; bus ignored
                    o_prog_level_en <= 1'b0;                      // [R16]
                    o_chip_select_n <= 1'b0;
                    o_output_gate_n <= 1'b1;                      // [R23]
                    o_dq_oe         <= 1'b1;
                    o_dq            <= `FPC_BLANK;                // [R17]
                    if (rcnt_q != {CW{1'b0}}) begin
                        rcnt_q <= rcnt_q - fit(1);
                        if (rcnt_q == fit(1)) begin
                            cyc_len_q   <= fit(RD_CYC);
                            cyc_start_q <= 1'b1;
                        end
                    end else if (cyc_done) begin
                        erase_q         <= 1'b1;                  // [R15]
                        o_prog_level_en <= 1'b1;
                        rcnt_q          <= fit(RD_CYC);
                        st_q            <= ST_WR;
                    end
                end
                ST_WR: begin
                    o_chip_select_n <= 1'b0;
                    o_output_gate_n <= 1'b1;                      // [R7]
                    o_dq_oe         <= 1'b1;
                    if (rcnt_q != {CW{1'b0}}) begin
                        rcnt_q <= rcnt_q - fit(1);
                        if (rcnt_q == fit(1)) begin
                            cyc_len_q   <= fit(WC_CYC);           // [R11] [R12]
                            cyc_start_q <= 1'b1;
                        end
                    end else if (cyc_done) begin
                        loop_q <= loop_q + 5'h01;
                        rcnt_q <= fit(RD_CYC);
                        if (erase_q && loop_q + 5'h01 < `FPC_ERASE_LOOPS) begin
                            st_q <= ST_SEL;                       // [R18] [R15]
                        end else if (!erase_q && loop_q + 5'h01 < `FPC_WRITE_LOOPS) begin
                            st_q <= ST_WR;                        // [R13]
                        end else begin
                            o_dq_oe         <= 1'b0;
                            o_prog_level_en <= 1'b0;
                            o_output_gate_n <= 1'b0;
                            vaddr_q         <= erase_q ? {AW{1'b0}} : o_addr;
                            if (erase_q) begin
                                o_addr <= {AW{1'b0}};
                            end
                            st_q <= ST_VFY;
                        end
                    end
                end
                ST_VFY: begin
                    // Read back; ones cannot be restored by writing
                    if (rcnt_q > fit(1)) begin
                        rcnt_q <= rcnt_q - fit(1);
                    end else if (erase_q) begin
                        if (i_dq != `FPC_BLANK) begin             // [R14] [R18]
                            o_ok <= 1'b0;
                            st_q <= ST_FINAL;
                        end else if (&vaddr_q) begin
                            o_ok <= 1'b1;
                            st_q <= ST_FINAL;
                        end else begin
                            vaddr_q <= vaddr_q + {{(AW-1){1'b0}}, 1'b1};
                            o_addr  <= vaddr_q + {{(AW-1){1'b0}}, 1'b1};
                            rcnt_q  <= fit(RD_CYC);
                        end
                    end else if (i_dq == o_dq || loop_q > `FPC_WRITE_LOOPS) begin
                        o_ok <= (i_dq == o_dq);                   // [R9]
                        st_q <= ST_FINAL;
                    end else begin
                        o_output_gate_n <= 1'b1;                  // [R13]
                        o_prog_level_en <= 1'b1;
                        rcnt_q          <= fit(RD_CYC);
                        st_q            <= ST_WR;
                    end
                end
                ST_FINAL: begin
                    o_output_gate_n <= 1'b1;
                    o_chip_select_n <= 1'b1;
                    erase_q <= 1'b0;
                    o_done  <= 1'b1;
                    o_busy  <= 1'b0;
                    st_q    <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verification/fpc_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_host_monitor #(
    parameter AW     = 16,
    parameter WC_CYC = 1500,
    parameter RD_CYC = 6
) (
    // Clock and reset
    input wire logic          i_ref_clk,
    input wire logic          i_rst,
    // User command port
    input wire logic          i_cmd_valid,
    input wire logic [2:0]    i_cmd,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0]    i_wdata,
    input wire logic          o_busy,
    input wire logic          o_done,
    input wire logic          o_ok,
    input wire logic [7:0]    o_rdata,
    // Device pins
    input wire logic [AW-1:0] o_addr,
    input wire logic [7:0]    i_dq,
    input wire logic [7:0]    o_dq,
    input wire logic          o_dq_oe,
    input wire logic          o_chip_select_n,
    input wire logic          o_output_gate_n,
    input wire logic          o_write_strobe_n,
    input wire logic          o_prog_level_en,
    input wire logic          o_sig_high_volt
);
    localparam int RDL = RD_CYC + 1;
    logic [15:0] lo_cnt_q;
    logic        take_rd;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    assign take_rd = i_cmd_valid && !o_busy && (i_cmd == 3'h0 || i_cmd == 3'h3 || i_cmd == 3'h4);
    ////////////////////////////////////////////////////////////////////////
    // Strobe low length
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst)
            lo_cnt_q <= 16'h0000;
        else if (o_write_strobe_n)
            lo_cnt_q <= 16'h0000;
        else
            lo_cnt_q <= lo_cnt_q + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    read_mode_a:
        assert property ((!o_chip_select_n && !o_output_gate_n) |-> (o_write_strobe_n && !o_dq_oe))
        else $error("read mode with strobe or host drive");
    write_combo_a:
        assert property (!o_write_strobe_n |-> (!o_chip_select_n && o_output_gate_n))
        else $error("strobe low without select low and gate high");
    bus_free_a:
        assert property (o_dq_oe |-> o_output_gate_n) else $error("host drives bus with gate low");
    latch_stable_a:
        assert property ((!o_write_strobe_n && $past(!o_write_strobe_n)) |->
            ($stable(o_addr) && $stable(o_dq) && $stable(o_prog_level_en)))
        else $error("address, data or level moved during strobe");
    wc_min_a:
        assert property (($rose(o_write_strobe_n) && $past(o_prog_level_en)) |-> lo_cnt_q >= WC_CYC)
        else $error("write strobe too short");
    sig_addr_a:
        assert property ((o_sig_high_volt && !o_chip_select_n && !o_output_gate_n) |->
            (o_addr[15:10] == 6'h00 && o_addr[8:1] == 8'h00))
        else $error("signature read with other address bits high");
    read_lat_a:
        assert property (take_rd |-> ##RDL o_done) else $error("read done late");
    ff_skip_a:
        assert property ((i_cmd_valid && !o_busy && i_cmd == 3'h1 && i_wdata == 8'hff)
            |=> (o_done && o_ok && o_write_strobe_n))
        else $error("blank byte not skipped");
    done_idle_a:
        assert property (o_done |-> (!o_busy && o_write_strobe_n) ##1 !o_done)
        else $error("done pulse malformed");
endmodule
bind fpc_host fpc_host_monitor #(.AW(AW), .WC_CYC(WC_CYC), .RD_CYC(RD_CYC)) mon (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_ok(o_ok),
    .o_rdata(o_rdata), .o_addr(o_addr), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_chip_select_n(o_chip_select_n), .o_output_gate_n(o_output_gate_n),
    .o_write_strobe_n(o_write_strobe_n), .o_prog_level_en(o_prog_level_en),
    .o_sig_high_volt(o_sig_high_volt));
`default_nettype wire

// ### verification/fpc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_dev_model #(
    parameter logic [7:0] MAKER = 8'h5c, // arbitrary value
    parameter logic [7:0] PROD  = 8'hc3  // arbitrary value
) (
    // Pins
    input wire logic  [15:0] i_addr,
    input wire logic  [7:0]  i_dq,
    output var logic  [7:0]  o_dq,
    input wire logic         i_cs_n,
    input wire logic         i_oe_n,
    input wire logic         i_we_n,
    input wire logic         i_prog,
    input wire logic         i_sig_hv,
    input wire logic         i_supply_ok
);
    logic [7:0]  mem [0:65535];
    logic [15:0] lat_addr;
    logic        erase_sel = 1'b0;
    realtime     t_fall;
    wire logic   wr_act = !i_cs_n && !i_we_n && i_oe_n;
    wire logic   drv    = !i_cs_n && !i_oe_n && i_we_n;
    wire logic   sig    = i_sig_hv && i_addr[15:10] == 6'h00 && i_addr[8:1] == 8'h00;
    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hff;
        o_dq = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Read and signature output; released bus shows inverse of last value
    always @(drv or sig or i_addr) begin
        if (drv)
            o_dq = sig ? (i_addr[0] ? PROD : MAKER) : mem[i_addr];
        else
            o_dq = ~o_dq;
    end
    ////////////////////////////////////////////////////////////////////////
    // Write latching on the later fall and the earlier rise
    always @(posedge wr_act) begin
        t_fall = $realtime;
        lat_addr = i_addr;
    end
    always @(negedge wr_act) begin
        if ($realtime - t_fall >= 20.0 && i_supply_ok) begin
            if (!i_prog) begin
                erase_sel = 1'b1;
            end else if (erase_sel && i_dq == 8'hff) begin
                for (int i = 0; i < 65536; i++)
                    mem[i] = 8'hff;
                erase_sel = 1'b0;
            end else begin
                mem[lat_addr] = mem[lat_addr] & i_dq;
                erase_sel = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/fpc_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpc_map.vh"
module fpc_host_tb;
    typedef struct packed {
        logic [2:0]  cmd;
        logic [15:0] addr;
        logic [7:0]  wd;
        logic [7:0]  er;
        logic        eok;
    } fpc_row_t;
    localparam int         WC = 20;
    localparam int         RD = 1;
    localparam logic [7:0] MK = 8'h5c;
    localparam logic [7:0] PC = 8'hc3;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cv  = 1'b0;
    logic [2:0]  cmd = 3'h0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wd  = 8'h00;
    logic        sup = 1'b1;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    wire logic   busy, done, ok, dq_oe, cs_n, oe_n, we_n, prog, sig;
    wire logic [7:0]  rdata, hdq, ddq;
    wire logic [15:0] pa;
    wire logic [7:0]  bus = dq_oe ? hdq : ddq;
    fpc_row_t    rows [10] = '{
        '{`FPC_CMD_WRITE, 16'h1234, 8'ha5, 8'h00, 1'b1}, '{`FPC_CMD_READ, 16'h1234, 8'h00, 8'ha5, 1'b1},
        '{`FPC_CMD_WRITE, 16'h1234, 8'h0f, 8'h00, 1'b0}, '{`FPC_CMD_READ, 16'h1234, 8'h00, 8'h05, 1'b1},
        '{`FPC_CMD_WRITE, 16'hffff, 8'hff, 8'h00, 1'b1}, '{`FPC_CMD_READ, 16'hffff, 8'h00, 8'hff, 1'b1},
        '{`FPC_CMD_SIG_MAKER, 16'h0000, 8'h00, MK, 1'b1}, '{`FPC_CMD_SIG_PROD, 16'h0000, 8'h00, PC, 1'b1},
        '{`FPC_CMD_WRITE, 16'h0000, 8'h3c, 8'h00, 1'b1}, '{`FPC_CMD_READ, 16'h0000, 8'h00, 8'h3c, 1'b1}};
    always #25 clk = ~clk;
    fpc_host #(.WC_CYC(WC), .RD_CYC(RD)) dut (
        .i_ref_clk(clk), .i_rst(rst), .i_cmd_valid(cv), .i_cmd(cmd), .i_addr(addr), .i_wdata(wd),
        .o_busy(busy), .o_done(done), .o_ok(ok), .o_rdata(rdata), .o_addr(pa), .i_dq(bus),
        .o_dq(hdq), .o_dq_oe(dq_oe), .o_chip_select_n(cs_n), .o_output_gate_n(oe_n),
        .o_write_strobe_n(we_n), .o_prog_level_en(prog), .o_sig_high_volt(sig));
    fpc_dev_model #(.MAKER(MK), .PROD(PC)) dev (
        .i_addr(pa), .i_dq(bus), .o_dq(ddq), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_prog(prog), .i_sig_hv(sig), .i_supply_ok(sup));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic run(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d, input int hold);
        int n;
        n = 0;
        @(posedge clk);
        cmd <= c;
        addr <= a;
        wd <= d;
        cv <= 1'b1;
        repeat (hold) @(posedge clk);
        cv <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 70000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1("done", 1'b1, done);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("[ERR] timeout expected done seen hang");
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        chk1("cs_n", 1'b1, cs_n);
        chk1("we_n", 1'b1, we_n);
        chk1("dq_oe", 1'b0, dq_oe);
        rst <= 1'b0;
        $display("reset test done");
        foreach (rows[i]) begin
            run(rows[i].cmd, rows[i].addr, rows[i].wd, 1);
            chk1("ok", rows[i].eok, ok);
            if (rows[i].cmd != `FPC_CMD_WRITE)
                chk8("rdata", rows[i].er, rdata);
        end
        $display("table test done");
        // Commands offered while busy are dropped
        run(`FPC_CMD_WRITE, 16'h0100, 8'h00, 1);
        @(posedge clk);
        cmd <= `FPC_CMD_WRITE;
        addr <= 16'h0200;
        wd <= 8'h00;
        cv <= 1'b1;
        @(posedge clk);
        addr <= 16'h0300;
        repeat (5) @(posedge clk);
        cv <= 1'b0;
        repeat (200) @(posedge clk);
        chk8("mem0200", 8'h00, dev.mem[16'h0200]);
        chk8("mem0300", 8'hff, dev.mem[16'h0300]);
        chk8("mem0100", 8'h00, dev.mem[16'h0100]);
        $display("busy test done");
        // Reset in mid write, then recovery
        @(posedge clk);
        cmd <= `FPC_CMD_WRITE;
        addr <= 16'h0400;
        wd <= 8'h81;
        cv <= 1'b1;
        @(posedge clk);
        cv <= 1'b0;
        repeat (15) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk1("we_n", 1'b1, we_n);
        chk1("busy", 1'b0, busy);
        @(posedge clk);
        rst <= 1'b0;
        // Aborted byte is undefined; recover on another address
        run(`FPC_CMD_WRITE, 16'h0500, 8'h81, 1);
        chk1("ok", 1'b1, ok);
        run(`FPC_CMD_READ, 16'h0500, 8'h00, 1);
        chk8("rdata", 8'h81, rdata);
        $display("abort test done");
        // Erase blocked by low supply, then full erase
        sup <= 1'b0;
        run(`FPC_CMD_ERASE, 16'h0000, 8'h00, 1);
        chk1("ok", 1'b0, ok);
        sup <= 1'b1;
        run(`FPC_CMD_ERASE, 16'h0000, 8'h00, 1);
        chk1("ok", 1'b1, ok);
        chk8("mem0000", 8'hff, dev.mem[16'h0000]);
        run(`FPC_CMD_READ, 16'h1234, 8'h00, 1);
        chk8("rdata", 8'hff, rdata);
        $display("erase test done");
        print_verdict();
    end
endmodule
`default_nettype wire
